/* crf_pkg.sv */
// Package for the core register file: register indices, flag layout, reset values.
// Assumes a single core clock domain and an APB-style register port.
package crf_pkg;

  localparam int unsigned DW = 32;
  localparam int unsigned AW = 12;

  // Word offsets (byte addresses) of the software view
  localparam logic [11:0] OFS_DATA0    = 12'h000;
  localparam logic [11:0] OFS_DATA1    = 12'h004;
  localparam logic [11:0] OFS_DATA2    = 12'h008;
  localparam logic [11:0] OFS_DATA3    = 12'h00C;
  localparam logic [11:0] OFS_ADDR0    = 12'h010;
  localparam logic [11:0] OFS_ADDR1    = 12'h014;
  localparam logic [11:0] OFS_FRAME    = 12'h018;
  localparam logic [11:0] OFS_VECBASE  = 12'h01C;
  localparam logic [11:0] OFS_IPTR     = 12'h020;
  localparam logic [11:0] OFS_USTACK   = 12'h024;
  localparam logic [11:0] OFS_ISTACK   = 12'h028;
  localparam logic [11:0] OFS_STATIC   = 12'h02C;
  localparam logic [11:0] OFS_FLAGS    = 12'h030;
  localparam logic [11:0] OFS_PAIRLO   = 12'h034;
  localparam logic [11:0] OFS_PAIRHI   = 12'h038;
  localparam logic [11:0] OFS_ADDRPAIR = 12'h03C;
  localparam logic [11:0] OFS_ACTSTACK = 12'h040;

  // Flag bit positions
  localparam int unsigned FB_CARRY = 0;
  localparam int unsigned FB_PROBE = 1;
  localparam int unsigned FB_ZERO  = 2;
  localparam int unsigned FB_NEG   = 3;
  localparam int unsigned FB_BANK  = 4;
  localparam int unsigned FB_OVF   = 5;
  localparam int unsigned FB_MASK  = 6;
  localparam int unsigned FB_STACK = 7;
  localparam int unsigned FB_IPL   = 12;
  localparam logic [15:0] FLAG_WMASK = 16'h70FF;

  localparam logic [15:0] RST_W16  = 16'h0000;
  localparam logic [19:0] RST_W20  = 20'h00000;
  localparam logic [10:0] RST_FLAG = 11'h000;
  localparam logic [4:0]  SWI_LAST = 5'h1F;

  // Status flags, 11 bits packed in field order
  typedef struct packed {
    logic [2:0] cpu_priority_level;
    logic       stack_choice;
    logic       mask_gate;
    logic       arith_wrap_bit;
    logic       regset_choice;
    logic       negative_bit;
    logic       result_null_bit;
    logic       probe_only_bit;
    logic       borrow_out_bit;
  } crf_flags_s;

  // One ALU flag update from the core
  typedef struct packed {
    logic upd_carry;
    logic carry;
    logic upd_zero;
    logic zero;
    logic upd_neg;
    logic neg;
    logic upd_ovf;
    logic ovf;
  } crf_alu_s;

  typedef struct packed {
    logic [15:0] data0;
    logic [15:0] data1;
    logic [15:0] data2;
    logic [15:0] data3;
    logic [15:0] addr0;
    logic [15:0] addr1;
    logic [15:0] frame;
  } crf_bank_s;

endpackage

/* crf_regfile.sv */
// Core register file with two banks, stack pointers and status flags.
// Assumes core decode/ALU/interrupt logic on the same clock; debug access over APB.
//
// Summary of operation
// [RULE_01] Seven banked registers exist twice; thirteen distinct register kinds overall.
// [RULE_02] Bank select flag zero picks bank 0, one picks bank 1.
// [RULE_03] Data registers are 16 bits; data0 and data1 bytes separately writable.
// [RULE_04] data2:data0 form data_pair_low, data3:data1 form data_pair_high.
// [RULE_05] Two 16-bit address registers, combinable as 32-bit addr_pair.
// [RULE_06] Frame base and static base pointers are 16-bit registers.
// [RULE_07] Vector table base is a 20-bit register.
// [RULE_08] Instruction pointer is a 20-bit register.
// [RULE_09] Stack select zero uses interrupt stack, one uses user stack.
// [RULE_10] Stack select cleared on hardware interrupt or software vector 0 to 31.
// [RULE_11] Status flag register is 11 bits.
// [RULE_12] Carry flag loaded with carry, borrow or shift-out bit.
// [RULE_13] Zero flag set on zero result, else cleared.
// [RULE_14] Sign flag set on negative result, else cleared.
// [RULE_15] Overflow flag set on overflow, else cleared.
// [RULE_16] Software keeps the debug flag at zero in normal use.
// [RULE_17] Maskable interrupts blocked while interrupt mask flag is zero.
// [RULE_18] Interrupt mask flag cleared when an interrupt is accepted.
// [RULE_19] Priority level is three bits, levels 0 to 7.
// [RULE_20] Request enabled only if priority strictly above current level.
// [RULE_21] Reserved flag bits written zero; read as zero here.
// [RULE_22] Undefined flags keep value; updates land on completing clock edge.
//
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/1ns
`default_nettype none

module crf_regfile
  import crf_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rst,
  // APB debug port
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [AW-1:0]     paddr,
  input  wire logic [DW-1:0]     pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [DW-1:0]     prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Core write port: index 0..12 as the APB word index
  input  wire logic              core_we,
  input  wire logic [3:0]        core_idx,
  input  wire logic [1:0]        core_be,
  input  wire logic [19:0]       core_wdata,
  input  wire logic              alu_valid,
  input  wire crf_alu_s          alu_flags,
  // Interrupt acceptance and requests
  input  wire logic              hw_irq_accept,
  input  wire logic              swi_exec,
  input  wire logic [5:0]        swi_vector,
  input  wire logic              irq_req,
  input  wire logic              irq_maskable,
  input  wire logic [2:0]        irq_prio,
  // Views toward the core
  output crf_bank_s              bank_out,
  output logic      [31:0]       data_pair_low,
  output logic      [31:0]       data_pair_high,
  output logic      [31:0]       addr_pair,
  output logic      [15:0]       active_stack,
  output logic      [15:0]       static_base_out,
  output logic      [19:0]       vector_base_out,
  output logic      [19:0]       iptr_out,
  output crf_flags_s             flags_out,
  output logic                   irq_enable
);

  crf_bank_s   bank_r [2];                                  // RULE_01
  logic [15:0] ustack_r;
  logic [15:0] istack_r;
  logic [15:0] static_r;
  logic [19:0] vecbase_r;
  logic [19:0] iptr_r;
  crf_flags_s  flags_r;

  logic        apb_we;
  logic [3:0]  apb_idx;
  logic        apb_hit;
  logic        sel;
  logic        wr_any;
  logic [3:0]  wr_idx;
  logic [1:0]  wr_be;
  logic [19:0] wr_data;

  // One-cycle access phase: single wait-free answer
  assign apb_hit = (paddr[1:0] == 2'h0) && (paddr <= OFS_ACTSTACK);
  // Pair and view words sit above the flags and are read-only; the active-stack
  // word index would otherwise wrap onto the banked data0 register
  assign apb_we  = psel && penable && pwrite && apb_hit && (paddr <= OFS_FLAGS);
  assign apb_idx = paddr[5:2];
  assign sel     = flags_r.regset_choice;                    // RULE_02

  // APB takes priority over the core on a same-cycle collision
  assign wr_any  = apb_we || core_we;
  assign wr_idx  = apb_we ? apb_idx : core_idx;
  assign wr_be   = apb_we ? {pstrb[1], pstrb[0]} : core_be;
  assign wr_data = apb_we ? pwdata[19:0] : core_wdata;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw,
                                          input logic [1:0] be);
    merge16 = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
  endfunction

  // Banked registers; byte lanes give the data0/data1 high and low bytes
  always_ff @(posedge clock) begin
    if (rst) begin
      bank_r[0] <= '0;
      bank_r[1] <= '0;
    end else if (wr_any) begin
      case (wr_idx)
        4'h0: bank_r[sel].data0 <= merge16(bank_r[sel].data0, wr_data[15:0], wr_be); // RULE_03
        4'h1: bank_r[sel].data1 <= merge16(bank_r[sel].data1, wr_data[15:0], wr_be); // RULE_03
        4'h2: bank_r[sel].data2 <= wr_data[15:0];
        4'h3: bank_r[sel].data3 <= wr_data[15:0];
        4'h4: bank_r[sel].addr0 <= wr_data[15:0];             // RULE_05
        4'h5: bank_r[sel].addr1 <= wr_data[15:0];             // RULE_05
        4'h6: bank_r[sel].frame <= wr_data[15:0];             // RULE_06
        default: ;
      endcase
    end
  end

  // Unbanked pointers
  always_ff @(posedge clock) begin
    if (rst) begin
      vecbase_r <= RST_W20;
      iptr_r    <= RST_W20;
      ustack_r  <= RST_W16;
      istack_r  <= RST_W16;
      static_r  <= RST_W16;
    end else if (wr_any) begin
      case (wr_idx)
        4'h7: vecbase_r <= wr_data;                            // RULE_07
        4'h8: iptr_r    <= wr_data;                            // RULE_08
        4'h9: ustack_r  <= wr_data[15:0];
        4'hA: istack_r  <= wr_data[15:0];
        4'hB: static_r  <= wr_data[15:0];                      // RULE_06
        default: ;
      endcase
    end
  end

  logic swi_low;
  assign swi_low = swi_exec && (swi_vector <= {1'b0, SWI_LAST});

  // Flags: explicit write, else ALU update; interrupt clears win last
  always_ff @(posedge clock) begin
    if (rst) begin
      flags_r <= RST_FLAG;
    end else begin
      if (wr_any && wr_idx == 4'hC) begin
        flags_r.borrow_out_bit     <= wr_data[FB_CARRY];
        flags_r.probe_only_bit     <= wr_data[FB_PROBE];      // RULE_16
        flags_r.result_null_bit    <= wr_data[FB_ZERO];
        flags_r.negative_bit       <= wr_data[FB_NEG];
        flags_r.regset_choice      <= wr_data[FB_BANK];
        flags_r.arith_wrap_bit     <= wr_data[FB_OVF];
        flags_r.mask_gate          <= wr_data[FB_MASK];
        flags_r.stack_choice       <= wr_data[FB_STACK];
        flags_r.cpu_priority_level <= wr_data[FB_IPL +: 3];   // RULE_19
      end else if (alu_valid) begin                           // RULE_22
        if (alu_flags.upd_carry) flags_r.borrow_out_bit  <= alu_flags.carry; // RULE_12
        if (alu_flags.upd_zero)  flags_r.result_null_bit <= alu_flags.zero;  // RULE_13
        if (alu_flags.upd_neg)   flags_r.negative_bit    <= alu_flags.neg;   // RULE_14
        if (alu_flags.upd_ovf)   flags_r.arith_wrap_bit  <= alu_flags.ovf;   // RULE_15
      end
      if (hw_irq_accept || swi_low) flags_r.stack_choice <= 1'b0; // RULE_10
      if (hw_irq_accept) flags_r.mask_gate <= 1'b0;                // RULE_18
    end
  end

  logic irq_en_nxt;
  assign irq_en_nxt = irq_req && (irq_prio > flags_r.cpu_priority_level) // RULE_20
                      && (!irq_maskable || flags_r.mask_gate);          // RULE_17

  // Registered views toward the core
  always_ff @(posedge clock) begin
    if (rst) begin
      bank_out        <= '0;
      data_pair_low   <= '0;
      data_pair_high  <= '0;
      addr_pair       <= '0;
      active_stack    <= RST_W16;
      static_base_out <= RST_W16;
      vector_base_out <= RST_W20;
      iptr_out        <= RST_W20;
      flags_out       <= RST_FLAG;
      irq_enable      <= 1'b0;
    end else begin
      bank_out        <= bank_r[sel];
      data_pair_low   <= {bank_r[sel].data2, bank_r[sel].data0}; // RULE_04
      data_pair_high  <= {bank_r[sel].data3, bank_r[sel].data1}; // RULE_04
      addr_pair       <= {bank_r[sel].addr1, bank_r[sel].addr0}; // RULE_05
      active_stack    <= flags_r.stack_choice ? ustack_r : istack_r; // RULE_09
      static_base_out <= static_r;
      vector_base_out <= vecbase_r;
      iptr_out        <= iptr_r;
      flags_out       <= flags_r;                             // RULE_11
      irq_enable      <= irq_en_nxt;
    end
  end

  logic [31:0] rd_val;
  logic [15:0] flag_word;
  // Reserved positions read back as zero
  assign flag_word = {1'b0, flags_r.cpu_priority_level, 4'h0, flags_r.stack_choice,
                      flags_r.mask_gate, flags_r.arith_wrap_bit, flags_r.regset_choice,
                      flags_r.negative_bit, flags_r.result_null_bit,
                      flags_r.probe_only_bit, flags_r.borrow_out_bit}; // RULE_21

  always_comb begin
    rd_val = '0;
    case (paddr)
      OFS_DATA0:    rd_val = {16'h0000, bank_r[sel].data0};
      OFS_DATA1:    rd_val = {16'h0000, bank_r[sel].data1};
      OFS_DATA2:    rd_val = {16'h0000, bank_r[sel].data2};
      OFS_DATA3:    rd_val = {16'h0000, bank_r[sel].data3};
      OFS_ADDR0:    rd_val = {16'h0000, bank_r[sel].addr0};
      OFS_ADDR1:    rd_val = {16'h0000, bank_r[sel].addr1};
      OFS_FRAME:    rd_val = {16'h0000, bank_r[sel].frame};
      OFS_VECBASE:  rd_val = {12'h000, vecbase_r};
      OFS_IPTR:     rd_val = {12'h000, iptr_r};
      OFS_USTACK:   rd_val = {16'h0000, ustack_r};
      OFS_ISTACK:   rd_val = {16'h0000, istack_r};
      OFS_STATIC:   rd_val = {16'h0000, static_r};
      OFS_FLAGS:    rd_val = {16'h0000, flag_word & FLAG_WMASK};
      OFS_PAIRLO:   rd_val = {bank_r[sel].data2, bank_r[sel].data0};
      OFS_PAIRHI:   rd_val = {bank_r[sel].data3, bank_r[sel].data1};
      OFS_ADDRPAIR: rd_val = {bank_r[sel].addr1, bank_r[sel].addr0};
      OFS_ACTSTACK: rd_val = {16'h0000, flags_r.stack_choice ? ustack_r : istack_r};
      default:      rd_val = '0;
    endcase
  end

  // Setup cycle registers the answer; access phase sees pready high
  always_ff @(posedge clock) begin
    if (rst) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !apb_hit;
      prdata  <= (psel && !penable && !pwrite) ? rd_val : '0;
    end
  end

  // Assertions
  bank_select_a: assert property (@(posedge clock) disable iff (rst) // RULE_02
    1'b1 |=> bank_out == $past(flags_r.regset_choice ? bank_r[1] : bank_r[0]))
    else $error("bank view mismatch");
  stack_sel_a: assert property (@(posedge clock) disable iff (rst) // RULE_09
    1'b1 |=> active_stack == ($past(flags_r.stack_choice) ? $past(ustack_r) : $past(istack_r)))
    else $error("active stack mismatch");
  stack_clear_a: assert property (@(posedge clock) disable iff (rst) // RULE_10
    (hw_irq_accept || swi_low) |=> !flags_r.stack_choice ##1 !flags_out.stack_choice)
    else $error("stack select not cleared");
  mask_clear_a: assert property (@(posedge clock) disable iff (rst) // RULE_18
    hw_irq_accept |=> !flags_r.mask_gate)
    else $error("mask gate not cleared");
  mask_block_a: assert property (@(posedge clock) disable iff (rst) // RULE_17
    (irq_maskable && !flags_r.mask_gate) |=> !irq_enable)
    else $error("masked interrupt enabled");
  prio_gate_a: assert property (@(posedge clock) disable iff (rst) // RULE_20
    (irq_prio <= flags_r.cpu_priority_level) |=> !irq_enable)
    else $error("low priority enabled");
  zero_flag_a: assert property (@(posedge clock) disable iff (rst) // RULE_13
    (alu_valid && alu_flags.upd_zero && !(wr_any && wr_idx == 4'hC))
      |=> flags_r.result_null_bit == $past(alu_flags.zero))
    else $error("zero flag wrong");
  carry_hold_a: assert property (@(posedge clock) disable iff (rst) // RULE_22
    (!alu_valid && !wr_any) |=> $stable(flags_r.borrow_out_bit))
    else $error("carry flag drifted");
  pair_low_a: assert property (@(posedge clock) disable iff (rst) // RULE_04
    1'b1 |=> data_pair_low[15:0] == $past(bank_r[sel].data0))
    else $error("pair low mismatch");
  apb_ready_a: assert property (@(posedge clock) disable iff (rst)
    (psel && !penable) |=> pready)
    else $error("apb answer late");

  bank1_cov_c: cover property (@(posedge clock) flags_r.regset_choice ##1 core_we);
  irq_cov_c:   cover property (@(posedge clock) hw_irq_accept ##1 !flags_r.mask_gate);
  swi_cov_c:   cover property (@(posedge clock) swi_low);
  apbw_cov_c:  cover property (@(posedge clock) apb_we && apb_idx == 4'hC);

endmodule // crf_regfile

`default_nettype wire

/* crf_core_model.sv */
// Behavioural core side: register writes, ALU flag updates, interrupt events.
// Assumes its tasks are called just after a rising edge of the core clock.
`timescale 1ns/1ns
`default_nettype none

module crf_core_model
  import crf_pkg::*;
(
  input  wire logic        clock,
  output logic             core_we,
  output logic [3:0]       core_idx,
  output logic [1:0]       core_be,
  output logic [19:0]      core_wdata,
  output logic             alu_valid,
  output crf_alu_s         alu_flags,
  output logic             hw_irq_accept,
  output logic             swi_exec,
  output logic [5:0]       swi_vector,
  output logic             irq_req,
  output logic             irq_maskable,
  output logic [2:0]       irq_prio
);
  initial begin
    {core_we, core_idx, core_be, core_wdata, alu_valid, alu_flags} = 36'h0;
    {hw_irq_accept, swi_exec, swi_vector, irq_req, irq_maskable, irq_prio} = 13'h0;
  end

  // Data is inverted once a pulse ends so nothing leans on stale values
  task automatic reg_write(input logic [3:0] idx, input logic [19:0] d);
    core_we <= 1'b1;
    core_idx <= idx;
    core_be <= 2'h3;
    core_wdata <= d;
    @(posedge clock);
    core_we <= 1'b0;
    core_wdata <= ~d;
  endtask

  task automatic alu_update(input crf_alu_s f);
    alu_valid <= 1'b1;
    alu_flags <= f;
    @(posedge clock);
    alu_valid <= 1'b0;
    alu_flags <= ~f;
  endtask

  task automatic hw_accept();
    hw_irq_accept <= 1'b1;
    @(posedge clock);
    hw_irq_accept <= 1'b0;
  endtask

  task automatic soft_int(input logic [5:0] v);
    swi_exec <= 1'b1;
    swi_vector <= v;
    @(posedge clock);
    swi_exec <= 1'b0;
    swi_vector <= ~v;
  endtask

  task automatic request(input logic m, input logic [2:0] p);
    irq_req <= 1'b1;
    irq_maskable <= m;
    irq_prio <= p;
  endtask
endmodule // crf_core_model
`default_nettype wire

/* tb_cpu_register_file_and_flags.sv */
// Self-checking bench: APB register access, core writes, flags, interrupt gating.
// Assumes crf_pkg, crf_regfile and crf_core_model are compiled first.
`timescale 1ns/1ns
`default_nettype none

module tb_cpu_register_file_and_flags;
  import crf_pkg::*;
  logic          clock, rst, psel, penable, pwrite, pready, pslverr, rerr;
  logic [AW-1:0] paddr;
  logic [DW-1:0] pwdata, prdata, rdata;
  logic [3:0]    pstrb, core_idx;
  logic [1:0]    core_be;
  logic [19:0]   core_wdata, vector_base_out, iptr_out;
  logic          core_we, alu_valid, hw_irq_accept, swi_exec, irq_req, irq_maskable;
  logic          irq_enable;
  crf_alu_s      alu_flags;
  logic [5:0]    swi_vector;
  logic [2:0]    irq_prio;
  crf_bank_s     bank_out;
  logic [31:0]   data_pair_low, data_pair_high, addr_pair;
  logic [15:0]   active_stack, static_base_out;
  crf_flags_s    flags_out;
  int            mismatches, n_compared, cycles;

  crf_regfile u_dut (.clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .core_we, .core_idx, .core_be, .core_wdata, .alu_valid,
    .alu_flags, .hw_irq_accept, .swi_exec, .swi_vector, .irq_req, .irq_maskable,
    .irq_prio, .bank_out, .data_pair_low, .data_pair_high, .addr_pair, .active_stack,
    .static_base_out, .vector_base_out, .iptr_out, .flags_out, .irq_enable);
  crf_core_model u_core (.clock, .core_we, .core_idx, .core_be, .core_wdata, .alu_valid,
    .alu_flags, .hw_irq_accept, .swi_exec, .swi_vector, .irq_req, .irq_maskable, .irq_prio);

  initial clock = 1'b0;
  always #2 clock = ~clock;

  // Scenarios need about two hundred cycles; generous ceiling
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      final_report();
    end
  end

  task automatic final_report();
    $display("compared=%0d mismatches=%0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Holds the request until pready is seen, then one idle cycle
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n == 16)
      mismatches++;
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
    apb(1'b1, a, d, s);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic err = 1'b0);
    apb(1'b0, a, 32'h0, 4'h0);
    chk(rdata, exp);
    chk({31'h0, rerr}, {31'h0, err});
  endtask

  task automatic t_bytes_pairs();
    wr(OFS_DATA0, 32'h00001234);
    wr(OFS_DATA0, 32'hFFFFAB56, 4'h1);
    rd(OFS_DATA0, 32'h00001256);
    wr(OFS_DATA1, 32'h00001111);
    wr(OFS_DATA1, 32'h0000CD78, 4'h2);
    rd(OFS_DATA1, 32'h0000CD11);
    wr(OFS_DATA2, 32'h00002222);
    wr(OFS_DATA3, 32'h00003333);
    wr(OFS_ADDR0, 32'h0000A0A0);
    wr(OFS_ADDR1, 32'h0000A1A1);
    wr(OFS_PAIRLO, 32'h00000000);
    wr(OFS_ACTSTACK, 32'h00000000);
    rd(OFS_PAIRLO, 32'h22221256);
    rd(OFS_PAIRHI, 32'h3333CD11);
    rd(OFS_ADDRPAIR, 32'hA1A1A0A0);
    chk(data_pair_low, 32'h22221256);
    chk(data_pair_high, 32'h3333CD11);
    chk(addr_pair, 32'hA1A1A0A0);
  endtask

  task automatic t_wide_bank();
    logic [11:0] ofs [4] = '{OFS_FRAME, OFS_STATIC, OFS_VECBASE, OFS_IPTR};
    logic [31:0] lim [4] = '{32'h0000FFFF, 32'h0000FFFF, 32'h000FFFFF, 32'h000FFFFF};
    foreach (ofs[i]) begin
      wr(ofs[i], 32'hFFFFFFFF);
      rd(ofs[i], lim[i]);
    end
    u_core.reg_write(4'h8, 20'h12345);
    repeat (2) @(posedge clock);
    chk({12'h000, iptr_out}, 32'h00012345);
    chk({12'h000, vector_base_out}, 32'h000FFFFF);
    chk({16'h0000, static_base_out}, 32'h0000FFFF);
    wr(OFS_FLAGS, 32'h00000010);
    wr(OFS_DATA0, 32'h0000BEEF);
    rd(OFS_FRAME, 32'h00000000);
    chk({16'h0000, bank_out.data0}, 32'h0000BEEF);
    u_core.reg_write(4'h6, 20'h0F00D);
    rd(OFS_FRAME, 32'h0000F00D);
    wr(OFS_FLAGS, 32'h00000000);
    rd(OFS_DATA0, 32'h00001256);
    rd(OFS_FRAME, 32'h0000FFFF);
  endtask

  task automatic t_stack_alu();
    wr(OFS_USTACK, 32'h00005555);
    wr(OFS_ISTACK, 32'h00006666);
    wr(OFS_FLAGS, 32'h000000C0);
    rd(OFS_ACTSTACK, 32'h00005555);
    chk({16'h0000, active_stack}, 32'h00005555);
    u_core.hw_accept();
    rd(OFS_FLAGS, 32'h00000000);
    rd(OFS_ACTSTACK, 32'h00006666);
    wr(OFS_FLAGS, 32'h00000080);
    u_core.soft_int(6'h20);
    rd(OFS_FLAGS, 32'h00000080);
    u_core.soft_int(6'h1F);
    rd(OFS_FLAGS, 32'h00000000);
    u_core.alu_update(8'hEF);
    rd(OFS_FLAGS, 32'h00000029);
    u_core.alu_update(8'h30);
    repeat (2) @(posedge clock);
    chk({31'h0, flags_out.result_null_bit}, 32'h00000001);
    rd(OFS_FLAGS, 32'h0000002D);
    u_core.alu_update(8'h82);
    rd(OFS_FLAGS, 32'h0000000C);
  endtask

  task automatic t_irq_err();
    logic [15:0] fw [6] = '{16'h3040, 16'h3040, 16'h3000, 16'h3000, 16'h7040, 16'h0040};
    logic [3:0]  mp [6] = '{4'hC, 4'hB, 4'hC, 4'h4, 4'hF, 4'h9};
    logic [5:0]  ex = 6'h29;
    foreach (fw[i]) begin
      wr(OFS_FLAGS, {16'h0000, fw[i]});
      u_core.request(mp[i][3], mp[i][2:0]);
      repeat (2) @(posedge clock);
      chk({31'h0, irq_enable}, {31'h0, ex[i]});
    end
    rd(12'h044, 32'h00000000, 1'b1);
    rd(12'h002, 32'h00000000, 1'b1);
    wr(OFS_FLAGS, 32'h000070FD);
    rd(OFS_FLAGS, 32'h000070FD);
    chk({29'h0, flags_out.cpu_priority_level}, 32'h00000007);
  endtask

  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata, pstrb} = 51'h0;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rd(OFS_FLAGS, 32'h00000000);
    t_bytes_pairs();
    t_wide_bank();
    t_stack_alu();
    t_irq_err();
    final_report();
  end
endmodule // tb_cpu_register_file_and_flags
`default_nettype wire
